/* File: design/tps_pkg.sv */
// constants and types for the timing pin routing block
package tps_pkg;
    localparam int CLK_PERIOD_PS = 8000;
    localparam int NUM_PINS      = 10;
    localparam int NUM_SIG       = 13;
    localparam int SEL_W         = 4;

    // routed signal indices
    localparam int SIG_START  = 0;
    localparam int SIG_SECOND = 1;
    localparam int SIG_GATE   = 4;
    localparam int SIG_SCLK   = 5;

    // signals that are always level detected; gate follows gate_edge_mode, all others are edge detected
    localparam logic [12:0] LEVEL_MASK = 13'h0020;

    localparam int START_PW_NS    = 25;
    localparam int START_PW_CYC   = (START_PW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SCAN_DLY_NS    = 50;
    localparam int SCAN_DLY_CYC   = (SCAN_DLY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SCAN_PW_NS     = 450;
    localparam int SCAN_PW_CYC    = (SCAN_PW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STB_SLOW_NS    = 10000;
    localparam int STB_FAST_NS    = 1200;
    localparam int STB_SLOW_HALF  = STB_SLOW_NS * 1000 / CLK_PERIOD_PS / 2;
    localparam int STB_FAST_HALF  = STB_FAST_NS * 1000 / CLK_PERIOD_PS / 2;
    localparam int STB_PULSES     = 8;

    localparam logic [9:0] PIN_OE_RST  = 10'h000;
    localparam logic       PREV_RST    = 1'b1;

    typedef enum logic [1:0] {
        ACQ_IDLE,
        ACQ_ARMED,
        ACQ_PRE,
        ACQ_POST
    } tps_acq_t;
endpackage

/* File: design/tps_route_if.sv */
// carrier between the top and the signal router
`timescale 1ns/1ps
interface tps_route_if;
    import tps_pkg::*;
    logic [NUM_PINS-1:0]      pins;
    logic [NUM_SIG*SEL_W-1:0] sel;
    logic [NUM_SIG-1:0]       pol;
    logic [NUM_SIG-1:0]       edge_sel;
    logic [NUM_SIG-1:0]       routed;
    modport ctrl  (output pins, sel, pol, edge_sel, input routed);
    modport route (input pins, sel, pol, edge_sel, output routed);
endinterface

/* File: design/tps_route.sv */
// per-signal pin selection, polarity and edge or level detection
`timescale 1ns/1ps
module tps_route (
    input  wire logic  clk,
    input  wire logic  rst_b,
    input  wire logic  ce,
    tps_route_if.route rif
);
    import tps_pkg::*;

    function automatic logic pick(input logic [NUM_PINS-1:0] p,
                                  input logic [SEL_W-1:0]    s);
        pick = (int'(s) < NUM_PINS) ? p[s] : 1'b0;
    endfunction

    logic [NUM_SIG-1:0] lvl;
    logic [NUM_SIG-1:0] prev_reg;
    logic [NUM_SIG-1:0] out_reg;
    logic [NUM_SIG-1:0] out_next;

    genvar g;
    generate
        for (g = 0; g < NUM_SIG; g++) begin : g_sig
            assign lvl[g] = pick(rif.pins, rif.sel[g*SEL_W +: SEL_W]) ^ rif.pol[g];
        end
    endgenerate

    assign out_next   = (rif.edge_sel & lvl & ~prev_reg) | (~rif.edge_sel & lvl);
    assign rif.routed = out_reg;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            prev_reg <= {NUM_SIG{PREV_RST}};
            out_reg  <= '0;
        end else if (ce) begin
            prev_reg <= lvl;
            out_reg  <= out_next;
        end
    end
endmodule

/* File: design/tps_top.sv */
// timing pin routing, start trigger, sampled indication and latch strobe
// Notes on behaviour
// - ten two-way timing pins carry external timing
// - each driven pin shows its fixed signal
// - any pin selectable per internal signal
// - per-pin software output driver enable
// - per-signal polarity, edge or level detection
// - detection mode fixed by the controlled signal, except gate set by gate_edge_mode
// - indication edge 50 to 100 ns after conversion
// - indication polarity and enable under software
// - indication pulse lasts 57 cycles, 456 ns
// - strobe has single and eight-pulse modes
// - single mode strobe level set by software
// - burst timed by 10 us or 1.2 us
// - start trigger from any pin, chosen edge
// - start edge begins post and pre modes
// - pin 0 start may be analog comparison
// - start output shows whatever actually started
// - start output high pulse 25 to 50 ns
// - start driver off until software enables it
// - software command can fire start trigger
// - pre mode: second trigger begins post phase
`timescale 1ns/1ps
module tps_top (
    input  wire logic                                     clk,
    input  wire logic                                     rst_b,
    input  wire logic                                     ce,
    input  wire logic [tps_pkg::NUM_PINS-1:0]             pin_in,
    output logic      [tps_pkg::NUM_PINS-1:0]             pin_out,
    output logic      [tps_pkg::NUM_PINS-1:0]             pin_oe,
    input  wire logic [tps_pkg::NUM_PINS-1:0]             pin_drive_en,
    input  wire logic [tps_pkg::NUM_PINS-1:2]             int_timing_out,
    input  wire logic [tps_pkg::NUM_SIG*tps_pkg::SEL_W-1:0] sig_sel,
    input  wire logic [tps_pkg::NUM_SIG-1:0]              sig_pol,
    input  wire logic                                     gate_edge_mode,
    output logic      [tps_pkg::NUM_SIG-1:0]              routed_sig,
    input  wire logic                                     analog_trig_en,
    input  wire logic                                     analog_cmp,
    input  wire logic                                     sw_start,
    input  wire logic                                     acq_arm,
    input  wire logic                                     pretrig_mode,
    input  wire logic                                     pre_count_done,
    input  wire logic                                     acq_stop,
    output logic                                          acq_active,
    output logic                                          post_phase,
    output logic                                          start_trigger,
    output logic                                          second_trigger,
    input  wire logic                                     conv_begin,
    input  wire logic                                     scan_pol,
    input  wire logic                                     scan_en,
    output logic                                          sampled_indication_pulse,
    output logic                                          sampled_indication_oe,
    input  wire logic                                     strobe_hw_mode,
    input  wire logic                                     strobe_fast,
    input  wire logic                                     strobe_sw_level,
    input  wire logic                                     strobe_go,
    output logic                                          external_latch_strobe_b,
    output logic                                          strobe_busy
);
    import tps_pkg::*;

    localparam logic [3:0]  START_PW  = 4'(START_PW_CYC);
    localparam logic [3:0]  SCAN_DLY  = 4'(SCAN_DLY_CYC);
    localparam logic [6:0]  SCAN_PW   = 7'(SCAN_PW_CYC);
    localparam logic [9:0]  HALF_SLOW = 10'(STB_SLOW_HALF);
    localparam logic [9:0]  HALF_FAST = 10'(STB_FAST_HALF);
    localparam logic [4:0]  STB_HALVES = 5'(2 * STB_PULSES);

    // ---------------- pin synchronisers ----------------
    // ten pins enter here
    logic [NUM_PINS-1:0] pin_meta_reg;
    logic [NUM_PINS-1:0] pin_sync_reg;
    logic                ana_meta_reg;
    logic                ana_sync_reg;

    // two flops before any use
    // reset to the idle pull-up level, so no false edge after reset
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pin_meta_reg <= {NUM_PINS{PREV_RST}};
            pin_sync_reg <= {NUM_PINS{PREV_RST}};
        end else if (ce) begin
            pin_meta_reg <= pin_in;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // comparator output is asynchronous as well
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ana_meta_reg <= 1'b0;
            ana_sync_reg <= 1'b0;
        end else if (ce) begin
            ana_meta_reg <= analog_cmp;
            ana_sync_reg <= ana_meta_reg;
        end
    end

    // ---------------- routing ----------------
    tps_route_if rif ();

    wire [NUM_PINS-1:0] pins_eff;
    wire [NUM_SIG-1:0]  edge_sel;

    assign pins_eff = {pin_sync_reg[NUM_PINS-1:1],
                       analog_trig_en ? ana_sync_reg : pin_sync_reg[0]};

    assign edge_sel = (~LEVEL_MASK & ~(NUM_SIG'(1) << SIG_GATE))
                    | ({NUM_SIG{gate_edge_mode}} & (NUM_SIG'(1) << SIG_GATE));

    assign rif.pins     = pins_eff;
    assign rif.sel      = sig_sel;
    assign rif.pol      = sig_pol;
    assign rif.edge_sel = edge_sel;

    tps_route u_route (
        .clk   (clk),
        .rst_b (rst_b),
        .ce    (ce),
        .rif   (rif)
    );

    assign routed_sig = rif.routed;

    // ---------------- acquisition sequence ----------------
    tps_acq_t acq_reg;
    tps_acq_t acq_next;
    logic     start_evt;
    logic     second_evt;
    logic     fire_start;
    logic     fire_second;

    wire      pin_start_evt;
    wire      sw_start_evt;

    assign pin_start_evt = rif.routed[SIG_START];
    assign sw_start_evt  = sw_start;
    assign start_evt     = pin_start_evt | sw_start_evt;
    assign second_evt    = rif.routed[SIG_SECOND];

    always_comb begin
        acq_next    = acq_reg;
        fire_start  = 1'b0;
        fire_second = 1'b0;
        case (acq_reg)
            ACQ_IDLE: begin
                if (acq_arm) begin
                    acq_next = ACQ_ARMED;
                end
            end
            ACQ_ARMED: begin
                if (start_evt) begin
                    fire_start = 1'b1;
                    acq_next   = pretrig_mode ? ACQ_PRE : ACQ_POST;
                end
            end
            ACQ_PRE: begin
                if (acq_stop) begin
                    acq_next = ACQ_IDLE;
                end else if (pre_count_done && second_evt) begin
                    fire_second = 1'b1;
                    acq_next    = ACQ_POST;
                end
            end
            ACQ_POST: begin
                if (acq_stop) begin
                    acq_next = ACQ_IDLE;
                end
            end
            default: begin
                acq_next = ACQ_IDLE;
            end
        endcase
    end

    // ---------------- trigger pulses ----------------
    logic [3:0] start_cnt_reg;
    logic [3:0] start_cnt_next;
    logic [3:0] second_cnt_reg;
    logic [3:0] second_cnt_next;

    // pulse from the event that started
    assign start_cnt_next = fire_start ? START_PW
                          : (start_cnt_reg != 4'h0) ? start_cnt_reg - 4'h1 : 4'h0;
    assign second_cnt_next = fire_second ? START_PW
                           : (second_cnt_reg != 4'h0) ? second_cnt_reg - 4'h1 : 4'h0;

    // sequence state and its status flags
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            acq_reg    <= ACQ_IDLE;
            acq_active <= 1'b0;
            post_phase <= 1'b0;
        end else if (ce) begin
            acq_reg    <= acq_next;
            acq_active <= (acq_next == ACQ_PRE) || (acq_next == ACQ_POST);
            post_phase <= acq_next == ACQ_POST;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            start_cnt_reg  <= 4'h0;
            second_cnt_reg <= 4'h0;
            start_trigger  <= 1'b0;
            second_trigger <= 1'b0;
        end else if (ce) begin
            start_cnt_reg  <= start_cnt_next;
            second_cnt_reg <= second_cnt_next;
            start_trigger  <= start_cnt_next != 4'h0;
            second_trigger <= second_cnt_next != 4'h0;
        end
    end

    // ---------------- pin drivers ----------------
    wire [NUM_PINS-1:0] pin_drive_val;

    assign pin_drive_val = {int_timing_out,
                            second_cnt_next != 4'h0,
                            start_cnt_next != 4'h0};

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pin_out <= '0;
            pin_oe  <= PIN_OE_RST;
        end else if (ce) begin
            pin_out <= pin_drive_val;
            pin_oe  <= pin_drive_en;
        end
    end

    // ---------------- sampled indication ----------------
    logic [3:0] scan_dly_reg;
    logic [3:0] scan_dly_next;
    logic [6:0] scan_pw_reg;
    logic [6:0] scan_pw_next;
    wire        scan_idle;
    wire        scan_load;

    assign scan_idle = (scan_dly_reg == 4'h0) && (scan_pw_reg == 7'h00);
    assign scan_load = scan_dly_reg == 4'h1;

    assign scan_dly_next = (conv_begin && scan_idle) ? SCAN_DLY
                         : (scan_dly_reg != 4'h0) ? scan_dly_reg - 4'h1 : 4'h0;
    assign scan_pw_next = scan_load ? SCAN_PW
                        : (scan_pw_reg != 7'h00) ? scan_pw_reg - 7'h01 : 7'h00;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            scan_dly_reg <= 4'h0;
            scan_pw_reg  <= 7'h00;
        end else if (ce) begin
            scan_dly_reg <= scan_dly_next;
            scan_pw_reg  <= scan_pw_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sampled_indication_pulse <= 1'b0;
            sampled_indication_oe    <= 1'b0;
        end else if (ce) begin
            sampled_indication_pulse <= (scan_pw_next != 7'h00) ^ scan_pol;
            sampled_indication_oe    <= scan_en;
        end
    end

    // ---------------- external latch strobe ----------------
    logic [9:0] stb_cnt_reg;
    logic [9:0] stb_cnt_next;
    logic [4:0] stb_half_reg;
    logic [4:0] stb_half_next;
    wire  [9:0] stb_half_len;
    wire        stb_start;
    wire        stb_wrap;
    wire        stb_hw_level;

    assign stb_half_len = strobe_fast ? HALF_FAST : HALF_SLOW;
    assign stb_start    = strobe_hw_mode && strobe_go && (stb_half_reg == 5'h00);
    assign stb_wrap     = stb_cnt_reg == 10'h001;
    // low in the first half of every period
    assign stb_hw_level = (stb_half_next == 5'h00) || stb_half_next[0];

    always_comb begin
        stb_cnt_next  = stb_cnt_reg;
        stb_half_next = stb_half_reg;
        if (!strobe_hw_mode) begin
            stb_cnt_next  = 10'h000;
            stb_half_next = 5'h00;
        end else if (stb_start) begin
            stb_cnt_next  = stb_half_len;
            stb_half_next = STB_HALVES;
        end else if (stb_half_reg != 5'h00) begin
            if (stb_wrap) begin
                stb_cnt_next  = stb_half_len;
                stb_half_next = stb_half_reg - 5'h01;
            end else begin
                stb_cnt_next = stb_cnt_reg - 10'h001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stb_cnt_reg  <= 10'h000;
            stb_half_reg <= 5'h00;
        end else if (ce) begin
            stb_cnt_reg  <= stb_cnt_next;
            stb_half_reg <= stb_half_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            external_latch_strobe_b <= 1'b1;
            strobe_busy             <= 1'b0;
        end else if (ce) begin
            strobe_busy <= stb_half_next != 5'h00;
            if (strobe_hw_mode) begin
                external_latch_strobe_b <= stb_hw_level;
            end else begin
                external_latch_strobe_b <= strobe_sw_level;
            end
        end
    end
endmodule

/* File: tb/tps_top_checker.sv */
// port assertions for the timing pin routing block
`timescale 1ns/1ps
module tps_top_checker (
    input wire logic                         clk,
    input wire logic                         rst_b,
    input wire logic [tps_pkg::NUM_PINS-1:0] pin_out,
    input wire logic [tps_pkg::NUM_SIG-1:0]  routed_sig,
    input wire logic                         sw_start,
    input wire logic                         pre_count_done,
    input wire logic                         start_trigger,
    input wire logic                         second_trigger,
    input wire logic                         post_phase,
    input wire logic                         conv_begin,
    input wire logic                         scan_pol,
    input wire logic                         sampled_indication_pulse,
    input wire logic                         strobe_hw_mode,
    input wire logic                         strobe_fast,
    input wire logic                         strobe_sw_level,
    input wire logic                         strobe_go,
    input wire logic                         external_latch_strobe_b,
    input wire logic                         strobe_busy
);
    import tps_pkg::*;
    logic       pol_reg;
    logic       stb_reg;
    logic [7:0] act_cnt_reg;
    logic [9:0] run_reg;
    // indication active level seen against last polarity
    wire        act = sampled_indication_pulse ^ pol_reg;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    always_ff @(posedge clk) begin
        pol_reg <= scan_pol;
        stb_reg <= external_latch_strobe_b;
        act_cnt_reg <= (act && rst_b) ? act_cnt_reg + 8'h01 : 8'h00;
        run_reg <= (external_latch_strobe_b != stb_reg) ? 10'h001 : run_reg + 10'h001;
    end
    a_start_width: assert property (
        $rose(start_trigger) |-> start_trigger[*4] ##1 !start_trigger)
        else $error("start pulse width wrong");
    a_start_cause: assert property (
        $rose(start_trigger) |-> $past(sw_start || routed_sig[0]))
        else $error("start pulse without cause");
    a_start_pin: assert property (
        pin_out[0] == start_trigger)
        else $error("pin 0 does not show start pulse");
    a_second_phase: assert property (
        $rose(second_trigger) |-> post_phase && $past(routed_sig[1] && pre_count_done))
        else $error("second trigger out of order");
    a_scan_delay: assert property (
        $rose(act) |-> $past(conv_begin, 8))
        else $error("indication delay wrong");
    a_scan_width: assert property (
        $fell(act) |-> act_cnt_reg == 8'h39)
        else $error("indication width wrong");
    a_strobe_go: assert property (
        strobe_hw_mode && strobe_go && !strobe_busy |=> !external_latch_strobe_b && strobe_busy)
        else $error("burst did not start");
    a_strobe_sw: assert property (
        !strobe_hw_mode |=> external_latch_strobe_b == $past(strobe_sw_level))
        else $error("single mode level wrong");
    a_strobe_half: assert property (
        strobe_busy && $past(strobe_busy) && strobe_hw_mode && $past(strobe_hw_mode)
            && external_latch_strobe_b != stb_reg |-> run_reg == (strobe_fast ? 10'h04B : 10'h271))
        else $error("burst half period wrong");
    c_start: cover property ($rose(start_trigger));
    c_second: cover property ($rose(second_trigger));
    c_burst: cover property ($fell(strobe_busy));
endmodule

/* File: tb/tps_ext_src.sv */
// external trigger sources; released pins sit at the pull-up level
`timescale 1ns/1ps
module tps_ext_src (
    input  wire logic [tps_pkg::NUM_PINS-1:0] pin_out,
    input  wire logic [tps_pkg::NUM_PINS-1:0] pin_oe,
    input  wire logic [tps_pkg::NUM_PINS-1:0] ext_en,
    input  wire logic [tps_pkg::NUM_PINS-1:0] ext_lvl,
    output logic      [tps_pkg::NUM_PINS-1:0] pin_in
);
    import tps_pkg::*;
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext_lvl) | ~ext_en));
endmodule

/* File: tb/test_tps_top.sv */
// self-checking bench for the timing pin routing block
`timescale 1ns/1ps
bind tps_top tps_top_checker i_tps_top_checker (.clk(clk), .rst_b(rst_b), .pin_out(pin_out),
    .routed_sig(routed_sig), .sw_start(sw_start), .pre_count_done(pre_count_done),
    .start_trigger(start_trigger), .second_trigger(second_trigger), .post_phase(post_phase),
    .conv_begin(conv_begin), .scan_pol(scan_pol),
    .sampled_indication_pulse(sampled_indication_pulse), .strobe_hw_mode(strobe_hw_mode),
    .strobe_fast(strobe_fast), .strobe_sw_level(strobe_sw_level), .strobe_go(strobe_go),
    .external_latch_strobe_b(external_latch_strobe_b), .strobe_busy(strobe_busy));
module test_tps_top;
    import tps_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1, gate_edge_mode = 1'b0, mon;
    logic [NUM_PINS-1:0] pin_in, pin_out, pin_oe, pin_drive_en = '0, ext_en = '0, ext_lvl = '0;
    logic [9:2] int_timing_out = 8'h00;
    logic [NUM_SIG*SEL_W-1:0] sig_sel = '0;
    logic [NUM_SIG-1:0] sig_pol = '0, routed_sig;
    logic analog_trig_en = 1'b0, analog_cmp = 1'b0, sw_start = 1'b0, acq_arm = 1'b0;
    logic pretrig_mode = 1'b0, pre_count_done = 1'b0, acq_stop = 1'b0, conv_begin = 1'b0;
    logic scan_pol = 1'b0, scan_en = 1'b0, strobe_hw_mode = 1'b0, strobe_fast = 1'b0;
    logic strobe_sw_level = 1'b1, strobe_go = 1'b0, acq_active, post_phase, start_trigger;
    logic second_trigger, sampled_indication_pulse, sampled_indication_oe;
    logic external_latch_strobe_b, strobe_busy;
    int fails = 0, checked = 0, psel = 0, dly, wid, h;
    always #4 clk = ~clk;
    assign mon = psel == 0 ? routed_sig[2] : psel == 1 ? start_trigger :
                 psel == 2 ? second_trigger : psel == 3 ? sampled_indication_pulse ^ scan_pol :
                 !external_latch_strobe_b;
    tps_top i_tps_top (.clk(clk), .rst_b(rst_b), .ce(ce), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_drive_en(pin_drive_en), .int_timing_out(int_timing_out),
        .sig_sel(sig_sel), .sig_pol(sig_pol), .gate_edge_mode(gate_edge_mode),
        .routed_sig(routed_sig), .analog_trig_en(analog_trig_en), .analog_cmp(analog_cmp),
        .sw_start(sw_start), .acq_arm(acq_arm), .pretrig_mode(pretrig_mode),
        .pre_count_done(pre_count_done), .acq_stop(acq_stop), .acq_active(acq_active),
        .post_phase(post_phase), .start_trigger(start_trigger), .second_trigger(second_trigger),
        .conv_begin(conv_begin), .scan_pol(scan_pol), .scan_en(scan_en),
        .sampled_indication_pulse(sampled_indication_pulse),
        .sampled_indication_oe(sampled_indication_oe), .strobe_hw_mode(strobe_hw_mode),
        .strobe_fast(strobe_fast), .strobe_sw_level(strobe_sw_level), .strobe_go(strobe_go),
        .external_latch_strobe_b(external_latch_strobe_b), .strobe_busy(strobe_busy));
    tps_ext_src i_tps_ext_src (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
        .ext_lvl(ext_lvl), .pin_in(pin_in));
    task automatic chk(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            fails++;
            $display("ERROR at %0t: %s", $time, msg);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // cycles until mon goes active, then cycles it stays active
    task automatic measure(input int lim);
        dly = 0;
        wid = 0;
        while (mon !== 1'b1 && dly < lim) begin
            @(negedge clk);
            dly++;
        end
        while (mon === 1'b1 && wid < lim) begin
            @(negedge clk);
            wid++;
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask
    task automatic pin(input int p, input logic v);
        ext_en[p] = 1'b1;
        ext_lvl[p] = v;
    endtask
    task automatic route(input int k, input int p, input logic pol);
        sig_sel[k*SEL_W +: SEL_W] = SEL_W'(p);
        sig_pol[k] = pol;
    endtask
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        cyc(40000);
        fails++;
        $display("ERROR at %0t: watchdog expired", $time);
        report_and_stop();
    end
    initial begin
        cyc(6);
        rst_b = 1'b1;
        cyc(1);
        chk(pin_oe === '0 && start_trigger === 1'b0 && external_latch_strobe_b === 1'b1, "reset");
        pin_drive_en = 10'h3FC;
        int_timing_out = 8'hA5;
        cyc(3);
        chk(pin_oe === 10'h3FC && pin_out[9:2] === 8'hA5, "pin drive");
        pin_drive_en = 10'h001;
        for (int p = 1; p < NUM_PINS; p++) begin
            route(2, p, 1'b0);
            pin(p, 1'b0);
            cyc(5);
            pin(p, 1'b1);
            measure(20);
            chk(dly == 3 && wid == 1, "routed edge");
        end
        route(2, 12, 1'b0);
        pin(3, 1'b0);
        cyc(5);
        pin(3, 1'b1);
        measure(10);
        chk(dly == 10, "no pin selected");
        route(5, 4, 1'b1);
        pin(4, 1'b0);
        cyc(8);
        chk(routed_sig[5] === 1'b1, "level low active");
        pin(4, 1'b1);
        cyc(4);
        chk(routed_sig[5] === 1'b0, "level released");
        ce = 1'b0;
        pin(4, 1'b0);
        cyc(6);
        chk(routed_sig[5] === 1'b0, "frozen while disabled");
        ce = 1'b1;
        cyc(4);
        chk(routed_sig[5] === 1'b1, "running again");
        pin(4, 1'b1);
        route(4, 6, 1'b0);
        cyc(4);
        chk(routed_sig[4] === 1'b1, "gate level mode");
        gate_edge_mode = 1'b1;
        cyc(2);
        chk(routed_sig[4] === 1'b0, "gate edge mode");
        route(0, 3, 1'b1);
        psel = 1;
        pin(3, 1'b0);
        measure(12);
        chk(dly == 12, "start while idle");
        pin(3, 1'b1);
        pulse(acq_arm);
        cyc(4);
        pin(3, 1'b0);
        measure(20);
        chk(dly == 4 && wid == 4 && acq_active === 1'b1 && post_phase === 1'b1, "post start");
        pulse(acq_stop);
        cyc(1);
        chk(acq_active === 1'b0, "stop");
        pretrig_mode = 1'b1;
        pulse(acq_arm);
        pulse(sw_start);
        measure(20);
        chk(dly == 0 && wid == 4 && post_phase === 1'b0 && acq_active === 1'b1, "sw start");
        route(1, 5, 1'b0);
        psel = 2;
        pin(5, 1'b0);
        cyc(5);
        pin(5, 1'b1);
        measure(12);
        chk(dly == 12, "second too early");
        pin(5, 1'b0);
        pre_count_done = 1'b1;
        cyc(5);
        pin(5, 1'b1);
        measure(20);
        chk(dly == 4 && wid == 4 && post_phase === 1'b1, "second trigger");
        pulse(acq_stop);
        pre_count_done = 1'b0;
        pretrig_mode = 1'b0;
        analog_trig_en = 1'b1;
        route(0, 0, 1'b0);
        pulse(acq_arm);
        analog_cmp = 1'b1;
        psel = 1;
        measure(20);
        chk(dly == 4 && wid == 4, "analog start");
        pulse(acq_stop);
        scan_en = 1'b1;
        psel = 3;
        for (int pol = 0; pol < 2; pol++) begin
            scan_pol = pol[0];
            cyc(3);
            chk(sampled_indication_pulse === pol[0] && sampled_indication_oe === 1'b1, "idle");
            pulse(conv_begin);
            cyc(1);
            pulse(conv_begin);
            measure(80);
            chk(dly == 5 && wid == SCAN_PW_CYC, "indication pulse");
            measure(80);
            chk(dly == 80, "indication refused while busy");
        end
        for (int v = 0; v < 2; v++) begin
            strobe_sw_level = v[0];
            cyc(2);
            chk(external_latch_strobe_b === v[0], "single level");
        end
        psel = 4;
        strobe_hw_mode = 1'b1;
        for (int f = 0; f < 2; f++) begin
            strobe_fast = f[0];
            h = f ? STB_FAST_HALF : STB_SLOW_HALF;
            pulse(strobe_go);
            for (int i = 0; i < STB_PULSES; i++) begin
                measure(700);
                chk(dly == (i ? h : 0) && wid == h, "burst pulse");
            end
            cyc(h);
            chk(strobe_busy === 1'b0 && external_latch_strobe_b === 1'b1, "burst end");
        end
        pulse(strobe_go);
        cyc(10);
        strobe_hw_mode = 1'b0;
        cyc(2);
        chk(external_latch_strobe_b === strobe_sw_level, "abort to single");
        report_and_stop();
    end
endmodule
